// file: logic/rspc_pkg.sv
/*
 * Constants and types for the reset strap and pin function block.
 * Assumes one 10 MHz clock and a chip reset that is asynchronous, active low.
 */
// Contract
// (R1) Reset pin clears all state asynchronously
// (R2) After reset, strap pins act as GPIO 0-2
// (R3) Pins 0-1 first control, pin 2 second
// (R4) Status shows live level and latched event
// (R5) Sample test pin at reset release
// (R6) High test strap enables factory test mode
// (R7) Board holds test strap low normally
// (R8) Two mode straps form host mode code
// (R9) After reset, test pin is GPIO 3
// (R10) After reset, first mode strap is select
// (R11) Outside master holds select low per access
// (R12) As master, drive select during autoconfig
// (R13) Strap values hold until next reset
// (R14) Pin change sets latched bit until cleared
package rspc_pkg;

    // Pin count and synchroniser depth
    localparam int          RSPC_PINS       = 4;
    localparam int          RSPC_SYNC_DEPTH = 2;
    // Cycles after release before straps are taken (synchroniser flush)
    localparam logic [1:0]  RSPC_SETTLE_CNT = 2'h2;
    localparam logic [1:0]  RSPC_CNT_ZERO   = 2'h0;
    localparam logic [1:0]  RSPC_CNT_ONE    = 2'h1;

    // Per-pin configuration field, four bits each
    localparam int          RSPC_FIELD_W    = 4;
    localparam int          RSPC_MODE_LSB   = 0;
    localparam logic [1:0]  RSPC_MODE_IN    = 2'h0;
    localparam logic [1:0]  RSPC_MODE_LOW   = 2'h1;
    localparam logic [1:0]  RSPC_MODE_HIGH  = 2'h2;

    // Field positions inside the control words
    localparam int          RSPC_CR1_PIN0   = 0;
    localparam int          RSPC_CR1_PIN1   = 4;
    localparam int          RSPC_CR2_PIN2   = 0;
    localparam int          RSPC_CR2_PIN3   = 4;

    // Reset values
    localparam logic [3:0]  RSPC_PINS_RST   = 4'h0;
    localparam logic [1:0]  RSPC_MODE_RST   = 2'h0;

    // Sampled strap values
    typedef struct packed {
        logic       test;
        logic [1:0] host_mode;
    } rspc_strap_t;

    // Pin status word: latched events above live levels
    typedef struct packed {
        logic [3:0] latched;
        logic [3:0] live;
    } rspc_status_t;

    typedef enum logic {
        RSPC_ST_SETTLE,
        RSPC_ST_RUN
    } rspc_state_t;

endpackage

// file: logic/rspc_top.sv
/*
 * Reset strap capture and pin function control.
 * Holds the strap capture after chip reset, the four general pins with
 * their configuration and status, and the serial select pin direction.
 * Assumes pad cells resolve pins from out/oe, and that an autoconfig
 * engine on the same clock drives the master-side select request.
 */
`timescale 1ns/1ps
module rspc_top (
    input  wire logic                  sys_clk,            // 10 MHz clock
    input  wire logic                  chip_reset_low,               // Chip reset, active low
    input  wire logic                  clk_en,             // Freezes state when low
    input  wire logic [3:0]            general_pin_in,     // Pad levels, pins 0..3
    output logic [3:0]                 general_pin_out,    // Pad drive values
    output logic [3:0]                 general_pin_oe,     // Pad drive enables
    input  wire logic [7:0]            pin_control_first,  // Pins 0 and 1 fields
    input  wire logic [7:0]            pin_control_second, // Pins 2 and 3 fields
    input  wire logic [3:0]            latch_clear,        // Clears latched bits
    output rspc_pkg::rspc_status_t     pin_status_reg,     // Live and latched status
    input  wire logic                  host_mode_strap_1,  // Second mode strap pad
    input  wire logic                  serial_select_in,   // Select pad level
    output logic                       serial_select_out,  // Select drive value
    output logic                       serial_select_oe,   // Select drive enable
    input  wire logic                  serial_master,      // Device is serial master
    input  wire logic                  autocfg_active,     // Autoconfig in progress
    input  wire logic                  autocfg_select,     // Autoconfig wants select
    output logic                       serial_select_low,  // Synced select level
    output rspc_pkg::rspc_strap_t      strap_value,        // Captured straps
    output logic                       factory_test,       // Factory test mode
    output logic                       straps_valid        // Straps captured
);
    import rspc_pkg::*;

    // Mode of one pin from its field
    function automatic logic [1:0] field_mode(input logic [3:0] fld);
        field_mode = fld[RSPC_MODE_LSB +: 2];
    endfunction

    // Synchronisers for every pad read by logic
    logic [3:0]  pin_s1_reg, pin_s1_next, pin_s2_reg, pin_s2_next;
    logic [3:0]  pin_prev_reg, pin_prev_next;
    logic        m1_s1_reg, m1_s1_next, m1_s2_reg, m1_s2_next;
    logic        cs_s1_reg, cs_s1_next, cs_s2_reg, cs_s2_next;

    // (R1) Sync stages reset; select stages preset high
    always_comb begin
        pin_s1_next   = pin_s1_reg;
        pin_s2_next   = pin_s2_reg;
        pin_prev_next = pin_prev_reg;
        m1_s1_next    = m1_s1_reg;
        m1_s2_next    = m1_s2_reg;
        cs_s1_next    = cs_s1_reg;
        cs_s2_next    = cs_s2_reg;
        if (clk_en) begin
            pin_s1_next   = general_pin_in;
            pin_s2_next   = pin_s1_reg;
            pin_prev_next = pin_s2_reg;
            m1_s1_next    = host_mode_strap_1;
            m1_s2_next    = m1_s1_reg;
            cs_s1_next    = serial_select_in;
            cs_s2_next    = cs_s1_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge chip_reset_low) begin
        if (!chip_reset_low) begin
            pin_s1_reg   <= RSPC_PINS_RST;
            pin_s2_reg   <= RSPC_PINS_RST;
            pin_prev_reg <= RSPC_PINS_RST;
            m1_s1_reg    <= 1'b0;
            m1_s2_reg    <= 1'b0;
            cs_s1_reg    <= 1'b1;
            cs_s2_reg    <= 1'b1;
        end else begin
            pin_s1_reg   <= pin_s1_next;
            pin_s2_reg   <= pin_s2_next;
            pin_prev_reg <= pin_prev_next;
            m1_s1_reg    <= m1_s1_next;
            m1_s2_reg    <= m1_s2_next;
            cs_s1_reg    <= cs_s1_next;
            cs_s2_reg    <= cs_s2_next;
        end
    end

    // Strap capture: straps cannot be flopped by the reset itself, so
    // they are taken once the synchronisers hold post-release levels.
    rspc_state_t state_reg, state_next;
    logic [1:0]  settle_reg, settle_next;
    rspc_strap_t strap_reg, strap_next;

    always_comb begin
        state_next  = state_reg;
        settle_next = settle_reg;
        strap_next  = strap_reg;
        if (clk_en) begin
            case (state_reg)
                RSPC_ST_SETTLE: begin
                    if (settle_reg == RSPC_CNT_ZERO) begin
                        // (R5) Test strap taken
                        strap_next.test      = pin_s2_reg[3];
                        // (R8) Mode code formed
                        strap_next.host_mode = {m1_s2_reg, cs_s2_reg};
                        state_next           = RSPC_ST_RUN;
                    end else begin
                        settle_next = settle_reg - RSPC_CNT_ONE;
                    end
                end
                // (R13) Straps frozen here
                RSPC_ST_RUN: state_next = RSPC_ST_RUN;
                default:     state_next = RSPC_ST_SETTLE;
            endcase
        end
    end

    // (R1) Capture restarts on reset
    always_ff @(posedge sys_clk or negedge chip_reset_low) begin
        if (!chip_reset_low) begin
            state_reg  <= RSPC_ST_SETTLE;
            settle_reg <= RSPC_SETTLE_CNT;
            strap_reg  <= '{test: 1'b0, host_mode: RSPC_MODE_RST};
        end else begin
            state_reg  <= state_next;
            settle_reg <= settle_next;
            strap_reg  <= strap_next;
        end
    end

    // Pin drive and status
    logic [3:0]  gp_out_reg, gp_out_next, gp_oe_reg, gp_oe_next;
    logic [3:0]  latch_reg, latch_next;
    logic [3:0]  cfg_fld [RSPC_PINS];
    logic        run;

    assign run        = (state_reg == RSPC_ST_RUN);
    // (R3) Field selection per pin
    assign cfg_fld[0] = pin_control_first[RSPC_CR1_PIN0 +: RSPC_FIELD_W];
    assign cfg_fld[1] = pin_control_first[RSPC_CR1_PIN1 +: RSPC_FIELD_W];
    assign cfg_fld[2] = pin_control_second[RSPC_CR2_PIN2 +: RSPC_FIELD_W];
    // (R9) Test pin as pin 3
    assign cfg_fld[3] = pin_control_second[RSPC_CR2_PIN3 +: RSPC_FIELD_W];

    always_comb begin
        gp_out_next = gp_out_reg;
        gp_oe_next  = gp_oe_reg;
        latch_next  = latch_reg;
        if (clk_en) begin
            for (int i = 0; i < RSPC_PINS; i++) begin
                // (R2) Drive only after straps taken
                gp_oe_next[i]  = 1'b0;
                gp_out_next[i] = 1'b0;
                if (run && field_mode(cfg_fld[i]) == RSPC_MODE_LOW) begin
                    gp_oe_next[i] = 1'b1;
                end
                if (run && field_mode(cfg_fld[i]) == RSPC_MODE_HIGH) begin
                    gp_oe_next[i]  = 1'b1;
                    gp_out_next[i] = 1'b1;
                end
                // (R14) Change sets, set beats clear
                if (latch_clear[i]) begin
                    latch_next[i] = 1'b0;
                end
                if (run && (pin_s2_reg[i] != pin_prev_reg[i])) begin
                    latch_next[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge chip_reset_low) begin
        if (!chip_reset_low) begin
            gp_out_reg <= RSPC_PINS_RST;
            gp_oe_reg  <= RSPC_PINS_RST;
            latch_reg  <= RSPC_PINS_RST;
        end else begin
            gp_out_reg <= gp_out_next;
            gp_oe_reg  <= gp_oe_next;
            latch_reg  <= latch_next;
        end
    end

    // Serial select direction; slave-side access framing is the master's job
    logic        cs_out_reg, cs_out_next, cs_oe_reg, cs_oe_next;

    always_comb begin
        cs_out_next = cs_out_reg;
        cs_oe_next  = cs_oe_reg;
        if (clk_en) begin
            // (R12) Master drives during autoconfig
            cs_oe_next  = run && serial_master && autocfg_active;
            // (R10) Active-low select
            cs_out_next = !(cs_oe_next && autocfg_select);
        end
    end

    always_ff @(posedge sys_clk or negedge chip_reset_low) begin
        if (!chip_reset_low) begin
            cs_out_reg <= 1'b1;
            cs_oe_reg  <= 1'b0;
        end else begin
            cs_out_reg <= cs_out_next;
            cs_oe_reg  <= cs_oe_next;
        end
    end

    // (R4) Live and latched status
    assign pin_status_reg    = '{latched: latch_reg, live: pin_s2_reg};
    assign general_pin_out   = gp_out_reg;
    assign general_pin_oe    = gp_oe_reg;
    assign serial_select_out = cs_out_reg;
    assign serial_select_oe  = cs_oe_reg;
    // (R11) Slave access seen as low level
    assign serial_select_low = cs_s2_reg;
    assign strap_value       = strap_reg;
    // (R6) Factory test from strap
    assign factory_test      = strap_reg.test;
    assign straps_valid      = run;

endmodule

// file: verification/rspc_monitor.sv
/* Port checker for rspc_top, bound after the module.
   Assumes pads and controls stay still while clk_en is low. */
`timescale 1ns/1ps
module rspc_monitor (
    input wire logic                   sys_clk,           // Clock
    input wire logic                   chip_reset_low,              // Reset
    input wire logic [3:0]             general_pin_in,    // Pin pads
    input wire logic                   host_mode_strap_1, // Mode strap pad
    input wire logic                   serial_select_in,  // Select pad
    input wire logic [3:0]             general_pin_oe,    // Pin enables
    input wire logic [3:0]             latch_clear,       // Clears
    input wire rspc_pkg::rspc_status_t pin_status_reg,    // Status
    input wire logic                   serial_master,     // Master role
    input wire logic                   autocfg_active,    // Autoconfig
    input wire logic                   autocfg_select,    // Select wish
    input wire logic                   serial_select_out, // Select drive
    input wire logic                   serial_select_oe,  // Select enable
    input wire rspc_pkg::rspc_strap_t  strap_value,       // Straps
    input wire logic                   factory_test,      // Test flag
    input wire logic                   straps_valid       // Captured
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!chip_reset_low);
    // Pads stay released until straps are in, or a strap could be overdriven
    no_early_drive_a: assert property (
        !straps_valid |-> general_pin_oe == 4'h0 && !serial_select_oe) else $error("early drive");
    strap_hold_a: assert property (
        $past(straps_valid) |-> $stable(strap_value)) else $error("strap moved");
    // Straps are the pad levels three edges before capture shows
    strap_take_a: assert property (
        $rose(straps_valid) |-> strap_value == {$past(general_pin_in[3], 3),
        $past(host_mode_strap_1, 3), $past(serial_select_in, 3)}) else $error("strap not taken");
    test_flag_a: assert property (
        factory_test == (straps_valid && strap_value.test)) else $error("test flag");
    latch_set_a: assert property (
        straps_valid && $past(straps_valid) && $changed(pin_status_reg.live[0])
        |=> pin_status_reg.latched[0]) else $error("change not latched");
    latch_hold_a: assert property (
        (~pin_status_reg.latched & $past(pin_status_reg.latched & ~latch_clear)) == 4'h0)
        else $error("latched bit lost");
    select_drive_a: assert property (
        straps_valid && serial_master && autocfg_active && autocfg_select
        |=> serial_select_oe && !serial_select_out) else $error("select not driven");
    select_off_a: assert property (
        !serial_master || !autocfg_active |=> !serial_select_oe) else $error("select held");
    select_idle_a: assert property (
        !serial_select_oe |-> serial_select_out) else $error("select idle low");
    cover property (factory_test);
    cover property (serial_select_oe);
    cover property (pin_status_reg.latched != 4'h0);
endmodule
bind rspc_top rspc_monitor i_rspc_monitor (.sys_clk, .chip_reset_low, .general_pin_in, .host_mode_strap_1,
    .serial_select_in, .general_pin_oe, .latch_clear,
    .pin_status_reg, .serial_master, .autocfg_active, .autocfg_select, .serial_select_out,
    .serial_select_oe, .strap_value, .factory_test, .straps_valid);

// file: verification/rspc_pads.sv
/* Board model: strap resistors, far-side drivers, pad resolution.
   Assumes the bench sets the board level of every pad. */
`timescale 1ns/1ps
module rspc_pads (
    input wire logic [3:0] board_pin, // Board level
    input wire logic [3:0] pin_out,   // Device drive
    input wire logic [3:0] pin_oe,    // Device enable
    input wire logic       board_sel, // Master level
    input wire logic       sel_out,   // Device drive
    input wire logic       sel_oe,    // Device enable
    output logic [3:0]     pin_pad,   // Pin level
    output logic           sel_pad    // Select level
);
    assign pin_pad = (pin_oe & pin_out) | (~pin_oe & board_pin);
    assign sel_pad = sel_oe ? sel_out : board_sel;
endmodule

// file: verification/testbench.sv
/* Bench for rspc_top with the rspc_pads board model.
   Assumes the monitor file is compiled alongside. */
`timescale 1ns/1ps
module testbench;
    logic                   sys_clk = 1'b0;
    logic                   chip_reset_low, clk_en, host_mode_strap_1, serial_select_in, serial_select_out;
    logic                   serial_select_oe, serial_master, autocfg_active, autocfg_select;
    logic                   serial_select_low, factory_test, straps_valid, board_sel;
    logic [3:0]             general_pin_in, general_pin_out, general_pin_oe, latch_clear, board_pin;
    logic [7:0]             pin_control_first, pin_control_second;
    rspc_pkg::rspc_status_t pin_status_reg;
    rspc_pkg::rspc_strap_t  strap_value;
    int                     fail_count = 0, tests_run = 0;
    rspc_top i_rspc_top (.sys_clk, .chip_reset_low, .clk_en, .general_pin_in, .general_pin_out,
        .general_pin_oe, .pin_control_first, .pin_control_second, .latch_clear, .pin_status_reg,
        .host_mode_strap_1, .serial_select_in, .serial_select_out, .serial_select_oe,
        .serial_master, .autocfg_active, .autocfg_select, .serial_select_low, .strap_value,
        .factory_test, .straps_valid);
    rspc_pads i_rspc_pads (.board_pin, .pin_out(general_pin_out), .pin_oe(general_pin_oe),
        .board_sel, .sel_out(serial_select_out), .sel_oe(serial_select_oe),
        .pin_pad(general_pin_in), .sel_pad(serial_select_in));
    // 10 MHz clock
    initial forever #50 sys_clk = ~sys_clk;
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        fail_count += int'(got !== exp);
        if (got !== exp) $display("mismatch at %0t: got %h, want %h", $time, got, exp);
    endtask
    task automatic finish_test();
        $display("compares %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic boot(input logic t, input logic s1, input logic s0);
        {chip_reset_low, board_pin, host_mode_strap_1, board_sel} = {1'b0, t, 3'h5, s1, s0};
        tick(1);
        cmp({serial_select_out, serial_select_oe, general_pin_oe, straps_valid}, 7'h40);
        tick(3);
        chip_reset_low = 1'b1;
        for (int i = 0; i < 8 && straps_valid !== 1'b1; i++)
            tick(1);
        cmp({straps_valid, factory_test, strap_value}, {1'b1, t, t, s1, s0});
    endtask
    // Straps, pin fields, status, select pin, then a reset in mid-run
    initial begin
        {clk_en, serial_master, autocfg_active, autocfg_select} = 4'h8;
        {pin_control_first, pin_control_second, latch_clear} = 20'h0;
        boot(1'b0, 1'b1, 1'b0);
        for (int p = 0; p < 4; p++)
            for (int m = 0; m < 4; m++) begin
                {pin_control_second, pin_control_first} = 16'(m) << (4 * p);
                tick(2);
                cmp({general_pin_oe, general_pin_out},
                    {4'(m == 1 || m == 2) << p, 4'(m == 2) << p});
            end
        // Enable low freezes the drive, which follows once it returns
        clk_en = 1'b0;
        pin_control_first = 8'h2;
        tick(2);
        cmp({general_pin_oe, general_pin_out}, 8'h00);
        clk_en = 1'b1;
        tick(2);
        cmp({general_pin_oe, general_pin_out}, 8'h11);
        // Clear is held long enough to outlast the set from settling pads
        {pin_control_second, pin_control_first, latch_clear} = 20'hF;
        board_pin = 4'h0;
        tick(6);
        latch_clear = 4'h0;
        for (int p = 0; p < 4; p++) begin
            board_pin[p] = 1'b1;
            tick(4);
            cmp(pin_status_reg, {2{4'hF >> (3 - p)}});
        end
        latch_clear = 4'h1;
        tick(2);
        latch_clear = 4'h0;
        cmp(pin_status_reg, 8'hEF);
        {serial_master, autocfg_active, autocfg_select, board_sel} = 4'hF;
        tick(2);
        cmp({serial_select_oe, serial_select_out, serial_select_in}, 3'h4);
        {serial_master, board_sel, host_mode_strap_1} = 3'h0;
        tick(4);
        cmp({serial_select_oe, serial_select_low, strap_value}, 5'h02);
        boot(1'b1, 1'b0, 1'b1);
        cmp(serial_select_low, 1'b1);
        finish_test();
    end
    // Hang guard, far beyond the 80 cycles the tests need
    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
endmodule
